// ===== design/acc_ctrl.sv
/*
  conversion control registers over apb and main converter run sequencing.
  assumes an apb master on pclk; result registers hold one redundant value.
*/
// Our own choice: the APB interface to the registers.
//
// Functional notes
// [RULE1] rate field sets current measurement period
// [RULE2] settings apply on go write; go reads 0; the filter enables follow ctrl_a on any write
// [RULE3] select field picks redundant channels sampled
// [RULE4] select zero scans all active cells
// [RULE5] select one is reserved, no shunt path
// [RULE6] codes 2..17 lock channels 1..16; the code drives aux_channel 0..15 for them
// [RULE7] inactive or reserved: skip, keep result reset; the code holds the last converted value instead
// [RULE8] run mode idle, single eight, continuous, reserved
`include "acc_defines.svh"
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned RATE0_CYC   = `ACC_RATE0_NS / `ACC_CLK_NS,
  parameter int unsigned RATE1_CYC   = `ACC_RATE1_NS / `ACC_CLK_NS,
  parameter int unsigned RATE2_CYC   = `ACC_RATE2_NS / `ACC_CLK_NS,
  parameter int unsigned RATE3_CYC   = `ACC_RATE3_NS / `ACC_CLK_NS,
  parameter logic [3:0]  SINGLE_RUNS = `ACC_SINGLE_RUNS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [15:0] active_cell_count_cfg,
  input  wire logic [15:0] aux_sample,
  output logic             main_running,
  output logic             cs_sample,
  output logic [1:0]       main_rate_sel,
  output logic             shunt_filter_enable,
  output logic             cell_voltage_filter_enable,
  output logic             aux_conv,
  output logic [3:0]       aux_channel,
  output logic [15:0]      redundant_cell_result
);
  function automatic logic [23:0] rate_cycles(input logic [1:0] code); // [RULE1]
    case (code)
      2'b00:   rate_cycles = 24'(RATE0_CYC);
      2'b01:   rate_cycles = 24'(RATE1_CYC);
      2'b10:   rate_cycles = 24'(RATE2_CYC);
      default: rate_cycles = 24'(RATE3_CYC);
    endcase
  endfunction : rate_cycles

  logic [15:0] active_s1;
  logic [15:0] active_s2;
  logic [7:0]  ctrl_a;
  logic [7:0]  redund;
  logic [1:0]  act_rate;
  acc_mode_e   act_mode;
  acc_state_e  state;
  acc_state_e  next_state;
  logic [23:0] period_cnt;
  logic [3:0]  runs;
  logic        aux_pend;

  acc_aux_if aux ();

  // apb decode
  wire        acc_phase = psel & penable;
  wire        hit_a     = paddr[13:0] == `ACC_ADDR_CTRL_A;
  wire        hit_r     = paddr[13:0] == `ACC_ADDR_REDUND;
  wire        hit       = (hit_a | hit_r) & paddr[15:14] == 2'b00 & paddr[1:0] == 2'b00;
  wire        wr_a      = acc_phase & pwrite & hit_a & hit;
  wire        wr_r      = acc_phase & pwrite & hit_r & hit;
  wire        go_wr     = wr_a & pwdata[`ACC_GO_BIT];               // [RULE2]
  wire [7:0]  rd_a      = ctrl_a & `ACC_CTRL_A_WMASK;               // [RULE2]
  // unmapped upper address bits must read zero, not alias a register
  wire [31:0] rd_mux    = ~hit ? 32'h0 : hit_a ? {24'h0, rd_a} : hit_r ? {24'h0, redund} : 32'h0;
  wire [7:0]  next_ctrl_a = wr_a ? pwdata[7:0] & `ACC_CTRL_A_WMASK : ctrl_a;
  wire [7:0]  next_redund = wr_r ? pwdata[7:0] & `ACC_REDUND_WMASK : redund;

  // main run sequencing
  wire        period_end = state == ACC_ST_RUN && period_cnt == 24'h0;
  wire        last_run   = act_mode == ACC_MODE_SINGLE && runs == SINGLE_RUNS - 4'h1;
  wire        go_run     = act_mode == ACC_MODE_SINGLE || act_mode == ACC_MODE_CONT;
  wire [1:0]  go_rate    = pwdata[6:5];
  acc_mode_e  go_mode;
  assign go_mode = acc_mode_e'(pwdata[1:0]);

  always_comb begin
    next_state = state;
    case (state)
      ACC_ST_IDLE: begin
        if (go_wr && (go_mode == ACC_MODE_SINGLE || go_mode == ACC_MODE_CONT)) begin // [RULE8]
          next_state = ACC_ST_RUN;
        end
      end
      ACC_ST_RUN: begin
        if (go_wr && !(go_mode == ACC_MODE_SINGLE || go_mode == ACC_MODE_CONT)) begin
          next_state = ACC_ST_IDLE;
        end else if (period_end && last_run && !go_wr) begin   // [RULE8]
          next_state = ACC_ST_IDLE;
        end
      end
      default: next_state = ACC_ST_IDLE;
    endcase
  end

  wire [23:0] next_period = go_wr ? rate_cycles(go_rate) - 24'h1 :
                            period_end ? rate_cycles(act_rate) - 24'h1 :
                            state == ACC_ST_RUN ? period_cnt - 24'h1 : period_cnt; // [RULE1]
  wire [3:0]  next_runs   = go_wr ? 4'h0 : period_end ? runs + 4'h1 : runs;
  wire        slot        = period_end & go_run;

  assign aux.sel         = redund[4:0];               // [RULE3]
  assign aux.active_mask = active_s2;                 // [RULE4]
  assign aux.slot_tick   = aux_pend;

  acc_aux_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .aux     (aux)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_s1 <= 16'h0;
      active_s2 <= 16'h0;
    end else begin
      active_s1 <= active_cell_count_cfg;
      active_s2 <= active_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a  <= `ACC_RST_CTRL_A;
      redund  <= `ACC_RST_REDUND;
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      ctrl_a  <= next_ctrl_a;
      redund  <= next_redund;
      pready  <= psel & ~penable;
      prdata  <= psel & ~penable & ~pwrite ? rd_mux : 32'h0;
      pslverr <= psel & ~penable & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_rate   <= 2'b00;
      act_mode   <= ACC_MODE_IDLE;
      state      <= ACC_ST_IDLE;
      period_cnt <= 24'h0;
      runs       <= 4'h0;
      aux_pend   <= 1'b0;
    end else begin
      if (go_wr) begin
        act_rate <= go_rate;                          // [RULE2]
        act_mode <= go_mode;
      end
      state      <= next_state;
      period_cnt <= next_period;
      runs       <= next_runs;
      aux_pend   <= slot;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_running               <= 1'b0;
      cs_sample                  <= 1'b0;
      main_rate_sel              <= 2'b00;
      shunt_filter_enable        <= 1'b0;
      cell_voltage_filter_enable <= 1'b0;
      aux_conv                   <= 1'b0;
      aux_channel                <= 4'h0;
      redundant_cell_result      <= `ACC_RST_RESULT;
    end else begin
      main_running               <= next_state == ACC_ST_RUN;
      cs_sample                  <= slot;
      main_rate_sel              <= act_rate;
      shunt_filter_enable        <= ctrl_a[4];
      cell_voltage_filter_enable <= ctrl_a[3];
      aux_conv                   <= aux.conv_en;
      aux_channel                <= aux.channel;
      if (aux.conv_en) begin
        redundant_cell_result <= aux_sample;          // [RULE7]
      end
    end
  end

  a_go_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    pready && !pwrite && hit_a && psel |-> prdata[`ACC_GO_BIT] == 1'b0)
    else $error("go bit read back as one");
  a_rate_no_go: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    wr_a && !go_wr |=> act_rate == $past(act_rate) && act_mode == $past(act_mode))
    else $error("settings changed without go");
  a_period_load: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    go_wr |=> period_cnt == rate_cycles($past(go_rate)) - 24'h1)
    else $error("period not loaded from rate code");
  a_idle_stays: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    state == ACC_ST_IDLE && !go_wr |=> state == ACC_ST_IDLE)
    else $error("left idle without go");
  a_single_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    period_end && last_run && !go_wr |=> state == ACC_ST_IDLE)
    else $error("single run did not stop after eight");
  a_cont_runs: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    state == ACC_ST_RUN && act_mode == ACC_MODE_CONT && !go_wr |=> state == ACC_ST_RUN)
    else $error("continuous run stopped");
  a_result_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    !aux.conv_en |=> redundant_cell_result == $past(redundant_cell_result))
    else $error("result changed on skipped slot");
  a_slot_follow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    slot |=> aux.slot_tick ##1 (aux.conv_en ^ aux.skipped))
    else $error("slot not served by sequencer");
endmodule : acc_ctrl
`default_nettype wire

// ===== inc/acc_defines.svh
/*
  constants for the conversion control block: offsets, fields, resets, timing.
  assumes a 100 MHz pclk.
*/
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_IDX_CTRL_A      12'h30d
`define ACC_IDX_REDUND      12'h30e
`define ACC_ADDR_CTRL_A     14'h0c34
`define ACC_ADDR_REDUND     14'h0c38
`define ACC_RST_CTRL_A      8'h00
`define ACC_RST_REDUND      8'h00
`define ACC_RST_RESULT      16'h0000
`define ACC_CTRL_A_WMASK    8'h7b
`define ACC_REDUND_WMASK    8'h3f
`define ACC_GO_BIT          2
`define ACC_SEL_ALL         5'h00
`define ACC_SEL_SHUNT       5'h01
`define ACC_SEL_FIRST       5'h02
`define ACC_SEL_LAST        5'h11
`define ACC_CLK_NS          10
`define ACC_RATE0_NS        768000
`define ACC_RATE1_NS        1536000
`define ACC_RATE2_NS        3072000
`define ACC_RATE3_NS        12288000
`define ACC_SINGLE_RUNS     4'h8
`define ACC_NUM_CELLS       16
`endif

// ===== inc/acc_pkg.sv
/*
  types for the conversion control block.
  assumes acc_defines.svh is on the include path.
*/
`default_nettype none
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_MODE_IDLE,
    ACC_MODE_SINGLE,
    ACC_MODE_CONT,
    ACC_MODE_RSVD
  } acc_mode_e;
  typedef enum {ACC_ST_IDLE, ACC_ST_RUN} acc_state_e;
endpackage : acc_pkg
`default_nettype wire

// ===== inc/acc_aux_if.sv
/*
  interface carrying the auxiliary sequencer controls and results.
  assumes one clock domain shared by both ends.
*/
`default_nettype none
interface acc_aux_if;
  logic [4:0]  sel;
  logic [15:0] active_mask;
  logic        slot_tick;
  logic        conv_en;
  logic [3:0]  channel;
  logic        skipped;
  modport ctrl (output sel, output active_mask, output slot_tick,
                input conv_en, input channel, input skipped);
  modport seq  (input sel, input active_mask, input slot_tick,
                output conv_en, output channel, output skipped);
endinterface : acc_aux_if
`default_nettype wire

// ===== design/acc_aux_seq.sv
/*
  auxiliary converter channel sequencer: decodes the redundant select code.
  assumes a slot tick from the control block, same clock.
*/
`include "acc_defines.svh"
`default_nettype none
module acc_aux_seq
  import acc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  acc_aux_if.seq    aux
);
  logic [3:0] scan;
  logic [3:0] next_scan;
  wire        sel_all    = aux.sel == `ACC_SEL_ALL;
  wire        sel_single = aux.sel >= `ACC_SEL_FIRST && aux.sel <= `ACC_SEL_LAST;
  wire [4:0]  sel_off    = aux.sel - `ACC_SEL_FIRST;
  wire [3:0]  lock_ch    = sel_off[3:0];
  wire [3:0]  cur_ch     = sel_all ? scan : lock_ch;
  // shunt code and 0x12..0x1f fall out as reserved
  wire        slot_ok    = (sel_all | sel_single) & aux.active_mask[cur_ch]; // [RULE5] [RULE7]

  assign next_scan = aux.slot_tick && sel_all ? scan + 4'h1 : scan; // [RULE4]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan        <= 4'h0;
      aux.conv_en <= 1'b0;
      aux.channel <= 4'h0;
      aux.skipped <= 1'b0;
    end else begin
      scan        <= next_scan;
      aux.conv_en <= aux.slot_tick & slot_ok;   // [RULE3] [RULE6]
      aux.channel <= cur_ch;
      aux.skipped <= aux.slot_tick & ~slot_ok;  // [RULE7]
    end
  end

  a_skip_on_rsvd: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    aux.slot_tick && aux.sel == `ACC_SEL_SHUNT |=> aux.skipped && !aux.conv_en)
    else $error("shunt select code did not skip");
  a_lock_channel: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    aux.slot_tick && sel_single |=> aux.channel == $past(lock_ch))
    else $error("locked channel mismatch");
endmodule : acc_aux_seq
`default_nettype wire

// ===== tb/tb_adc_conversion_control.sv
/*
  self-checking bench for acc_ctrl: apb register access, go bit, rates, run modes, aux select.
  assumes acc_defines.svh on the include path and acc_pkg compiled first.
*/
`include "acc_defines.svh"
`default_nettype none
module tb_adc_conversion_control
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RATE [4] = '{20, 40, 80, 320};
  localparam logic [15:0] A_CTRL = 16'(`ACC_ADDR_CTRL_A);
  localparam logic [15:0] A_RED  = 16'(`ACC_ADDR_REDUND);
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000, active_cell_count_cfg = 16'h0005, aux_sample = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, main_running, cs_sample, aux_conv;
  logic        shunt_filter_enable, cell_voltage_filter_enable;
  logic [1:0]  main_rate_sel;
  logic [3:0]  aux_channel;
  logic [15:0] redundant_cell_result;
  int          fails = 0, total_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  acc_ctrl #(.RATE0_CYC(RATE[0]), .RATE1_CYC(RATE[1]), .RATE2_CYC(RATE[2]),
             .RATE3_CYC(RATE[3])) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .active_cell_count_cfg(active_cell_count_cfg), .aux_sample(aux_sample),
    .main_running(main_running), .cs_sample(cs_sample), .main_rate_sel(main_rate_sel),
    .shunt_filter_enable(shunt_filter_enable),
    .cell_voltage_filter_enable(cell_voltage_filter_enable), .aux_conv(aux_conv),
    .aux_channel(aux_channel), .redundant_cell_result(redundant_cell_result));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, a, {24'h0, d}, rd, e);
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input logic experr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, {24'h0, exp});
    chk({31'h0, e}, {31'h0, experr});
  endtask : rdchk
  task automatic wait_cs(output int n);
    n = 0;
    do begin @(posedge pclk); n++; end while (cs_sample !== 1'b1 && n < 2000);
  endtask : wait_cs
  task automatic watch(input int c, output int cnt, output int ch, output int nbad,
                       output int nrep);
    int prev;
    cnt = 0; nbad = 0; nrep = 0; prev = -1; ch = -1;
    repeat (c) begin
      @(posedge pclk);
      if (aux_conv === 1'b1) begin
        cnt++;
        if (active_cell_count_cfg[aux_channel] !== 1'b1) nbad++;
        if (int'(aux_channel) == prev) nrep++;
        ch = int'(aux_channel);
        prev = ch;
      end
    end
    repeat (3) @(posedge pclk);
  endtask : watch
  task automatic t_regs();
    rdchk(A_CTRL, `ACC_RST_CTRL_A, 1'b0);
    rdchk(A_RED, `ACC_RST_REDUND, 1'b0);
    wr(A_CTRL, 8'hff);
    rdchk(A_CTRL, 8'h7b, 1'b0);
    chk({30'h0, shunt_filter_enable, cell_voltage_filter_enable}, 32'h3);
    wr(A_RED, 8'hff);
    rdchk(A_RED, 8'h3f, 1'b0);
    wr(16'h0c3c, 8'h00);
    rdchk(16'h0c3c, 8'h00, 1'b1);
    rdchk(16'h4c34, 8'h00, 1'b1);
    rdchk(A_RED, 8'h3f, 1'b0);
    wr(A_CTRL, 8'h04);
    $display("test regs done");
  endtask : t_regs
  task automatic t_go();
    wr(A_CTRL, 8'h42);
    repeat (50) @(posedge pclk);
    chk({30'h0, main_rate_sel}, 32'h0);
    chk({31'h0, main_running}, 32'h0);
    rdchk(A_CTRL, 8'h42, 1'b0);
    wr(A_CTRL, 8'h26);
    rdchk(A_CTRL, 8'h22, 1'b0);
    chk({30'h0, main_rate_sel}, 32'h1);
    chk({31'h0, main_running}, 32'h1);
    $display("test go done");
  endtask : t_go
  task automatic t_rate();
    int n;
    for (int r = 0; r < 4; r++) begin
      wr(A_CTRL, 8'(r << 5) | 8'h06);
      repeat (3) wait_cs(n);
      chk(32'(n), 32'(RATE[r]));
    end
    $display("test rate done");
  endtask : t_rate
  task automatic t_single();
    int cnt;
    cnt = 0;
    wr(A_CTRL, 8'h04);
    wr(A_CTRL, 8'h05);
    repeat (8 * RATE[0] + 100) begin @(posedge pclk); if (cs_sample === 1'b1) cnt++; end
    chk(32'(cnt), 32'h8);
    chk({31'h0, main_running}, 32'h0);
    wr(A_CTRL, 8'h06);
    wr(A_CTRL, 8'h07);
    repeat (5) @(posedge pclk);
    chk({31'h0, main_running}, 32'h0);
    $display("test single done");
  endtask : t_single
  task automatic t_aux();
    int cnt, ch, nb, nr;
    logic [4:0] skip [4] = '{5'h01, 5'h03, 5'h12, 5'h1f};
    wr(A_CTRL, 8'h06);
    foreach (skip[i]) begin
      wr(A_RED, {3'h0, skip[i]});
      watch(120, cnt, ch, nb, nr);
      chk(32'(cnt), 32'h0);
      chk({16'h0, redundant_cell_result}, 32'(`ACC_RST_RESULT));
    end
    aux_sample <= 16'h0abc;
    wr(A_RED, 8'h00);
    watch(400, cnt, ch, nb, nr);
    chk(32'(cnt >= 2), 32'h1);
    chk(32'(nb + nr), 32'h0);
    active_cell_count_cfg <= 16'hffff;
    for (int k = 0; k < 16; k += 5) begin
      aux_sample <= 16'h1230 + 16'(k);
      wr(A_RED, 8'h02 + 8'(k));
      watch(100, cnt, ch, nb, nr);
      chk(32'(ch), 32'(k));
      chk({16'h0, redundant_cell_result}, 32'h1230 + 32'(k));
    end
    $display("test aux done");
  endtask : t_aux
  task automatic t_reset();
    wr(A_CTRL, 8'h06);
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, main_running}, 32'h0);
    presetn <= 1'b1;
    rdchk(A_CTRL, `ACC_RST_CTRL_A, 1'b0);
    chk({16'h0, redundant_cell_result}, 32'(`ACC_RST_RESULT));
    $display("test reset done");
  endtask : t_reset
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_go();
    t_rate();
    t_single();
    t_aux();
    t_reset();
    report_and_stop();
  end
endmodule : tb_adc_conversion_control
`default_nettype wire
